//--- shared/coc_pkg.sv
// shared constants, types and helpers for the configuration overlay command handler
package coc_pkg;
	// command and subcommand codes
	localparam logic [7:0] OPC_OVERLAY = 8'hb1;
	localparam logic [7:0] SUB_RESTORE = 8'hc0;
	localparam logic [7:0] SUB_FREEZE = 8'hc1;
	localparam logic [7:0] SUB_IDENTIFY = 8'hc2;
	localparam logic [7:0] SUB_SET = 8'hc3;
	// overlay data block layout, in 16-bit words
	localparam logic [7:0] LAST_WORD = 8'hff;
	localparam logic [7:0] W_REV = 8'h00;
	localparam logic [7:0] W_MDMA = 8'h01;
	localparam logic [7:0] W_UDMA = 8'h02;
	localparam logic [7:0] W_LBA0 = 8'h03;
	localparam logic [7:0] W_LBA1 = 8'h04;
	localparam logic [7:0] W_LBA2 = 8'h05;
	localparam logic [7:0] W_FEAT = 8'h07;
	localparam logic [7:0] W_FEAT2 = 8'h08;
	localparam logic [15:0] REV_VAL = 16'h0002;
	localparam logic [7:0] SIG_VAL = 8'ha5;
	// full selectable capabilities (plain defaults)
	localparam logic [15:0] FULL_MDMA = 16'h0007;
	localparam logic [15:0] FULL_UDMA = 16'h007f;
	localparam logic [47:0] FULL_LBA = 48'h0000_1000_0000;
	localparam logic [15:0] FULL_FEAT = 16'h1bff;
	localparam logic [15:0] FULL_FEAT2 = 16'h0016;
	// abort reason codes
	localparam logic [7:0] RSN_NONE = 8'h00;
	localparam logic [7:0] RSN_CSUM = 8'h01;
	localparam logic [7:0] RSN_FROZEN = 8'h02;
	localparam logic [7:0] RSN_SECURITY = 8'h04;
	localparam logic [7:0] RSN_HPA = 8'h06;
	localparam int SEC_BIT = 3;
	localparam logic [7:0] SEC_BIT_LOC = 8'h03;
	// task-file status and error bit positions
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_ABT = 2;
	// register map (byte addresses)
	localparam logic [7:0] A_IRQ_STS = 8'h00;
	localparam logic [7:0] A_IRQ_MASK = 8'h04;
	localparam logic [7:0] A_CTRL = 8'h08;
	localparam logic [7:0] A_STATE = 8'h0c;
	localparam logic [7:0] A_ERR = 8'h10;
	localparam logic [7:0] A_STAT = 8'h14;
	localparam logic [7:0] A_REASON = 8'h18;
	localparam logic [7:0] A_CAP = 8'h1c;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_W = 2;
	// command engine states
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_TX = 4'b0010,
		S_RX = 4'b0100,
		S_CHK = 4'b1000
	} coc_state_t;
	// sum of both bytes of a word, overflow dropped
	function automatic logic [7:0] coc_bsum(input logic [15:0] w);
		return w[15:8] + w[7:0];
	endfunction : coc_bsum
	// integrity byte of the identify block, fixed since its content is fixed
	localparam logic [7:0] ID_CSUM = 8'h00 - (coc_bsum(REV_VAL) + coc_bsum(FULL_MDMA)
		+ coc_bsum(FULL_UDMA) + coc_bsum(FULL_LBA[15:0]) + coc_bsum(FULL_LBA[31:16])
		+ coc_bsum(FULL_LBA[47:32]) + coc_bsum(FULL_FEAT) + coc_bsum(FULL_FEAT2) + SIG_VAL);
endpackage : coc_pkg

//--- design/coc_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module coc_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, active high
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta_q; // first stage, read only by the second
	// plain two-stage chain
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : coc_sync

//--- design/coc_csum.sv
// running byte sum of a stream of 16-bit words
`timescale 1ns/10ps
module coc_csum
	import coc_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, active high
	input wire logic clr, // restart the sum
	input wire logic add, // word present this cycle
	input wire logic [15:0] word, // word to add
	output logic [7:0] sum_q // sum of all bytes so far
);
	// overflow ignored, so a correct block sums to zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sum_q <= 8'h00;
		end else if (clr) begin
			sum_q <= 8'h00;
		end else if (add) begin
			sum_q <= sum_q + coc_bsum(word);
		end
	end
endmodule : coc_csum

//--- design/coc_overlay.sv
// configuration overlay command handler with its register slave
// What this block does
// - opcode b1h selects the overlay command family
// - feature c0h restore, c1h freeze, c2h identify
// - feature c3h selects set, overlay sent in
// - restore brings back full capabilities
// - after freeze, every overlay subcommand aborts
// - freeze clears only at power-up reset
// - identify returns 512 bytes by data-in
// - reported caps reduced, identify block stays full
// - set may clear capability bits, withdrawing support
// - bits not offered stay unchanged, no action
// - broken restriction aborts the set command
// - abort reports reason, word and bit
// - protected area blocks max address change, 03h/06h
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module coc_overlay
	import coc_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // power-up reset, async, active high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic tf_cmd_wr, // command register written, pulse
	input wire logic [7:0] tf_command, // command register value
	input wire logic [7:0] tf_feature, // feature register value
	input wire logic ata_hard_reset, // hardware reset pulse
	input wire logic ata_soft_reset, // software reset pulse
	input wire logic [15:0] pio_in_data, // data-out word from host
	input wire logic pio_in_valid, // data-out word valid
	output logic pio_in_ready, // device takes data-out word
	output logic [15:0] pio_out_data, // data-in word to host
	output logic pio_out_valid, // data-in word valid
	input wire logic pio_out_ready, // host takes data-in word
	output logic tf_done, // command complete, pulse
	output logic [7:0] tf_status, // device condition flags
	output logic [7:0] tf_error, // command error flags
	output logic [7:0] tf_sector_count, // abort reason code
	output logic [7:0] tf_cyl_high, // offending word index
	output logic [7:0] tf_cyl_low, // offending bit position
	input wire logic hpa_established_pin, // protected area set up, async
	input wire logic security_enabled_pin, // security enabled, async
	output logic dco_frozen, // freeze lock in force
	output logic [15:0] cap_mdma, // reported multiword dma modes
	output logic [15:0] cap_udma, // reported ultra dma modes
	output logic [47:0] cap_max_lba, // reported maximum address
	output logic [15:0] cap_feat, // reported feature sets
	output logic [15:0] cap_feat2, // reported further feature sets
	output logic irq // level interrupt
);
	coc_state_t st_q, st_d; // command engine state
	logic [1:0] pin_s; // synchronised pin levels
	logic hpa_s, sec_s; // protected area, security
	logic [7:0] wcnt_q; // word index in the data block
	logic frozen_q; // freeze lock
	logic [15:0] mdma_q, udma_q, feat_q, feat2_q; // reported caps
	logic [47:0] lba_q; // reported max address
	logic [15:0] rx_mdma_q, rx_udma_q, rx_feat_q, rx_feat2_q; // received overlay
	logic [47:0] rx_lba_q; // received max address
	logic [7:0] rx_sig_q, rx_sum; // received signature, byte sum
	logic [47:0] new_lba; // max address that a set would leave
	logic fin, fin_abt, do_restore, do_freeze, do_apply; // engine events
	logic [7:0] rsn, wloc, bloc; // abort report
	logic accept, abort_xfer, in_fire, out_fire; // handshakes
	logic [15:0] out_d; // next data-in word
	logic [IRQ_W-1:0] sts_q, mask_q; // interrupt status and mask
	logic [7:0] aw_addr_q; // held write address
	logic [31:0] w_data_q; // held write data
	logic [3:0] w_strb_q; // held write strobes
	logic aw_held_q, w_held_q, wr_do, wr_ok; // write collection
	logic [31:0] rd_d; // read mux
	logic rd_ok; // read address mapped
	logic ctrl_cancel; // software cancels a transfer
	logic tf_done_q, irq_q, pio_in_ready_q, pio_out_valid_q; // output flops
	logic [15:0] pio_out_data_q; // data-in word flop
	logic [7:0] status_q, error_q, sc_q, ch_q, cl_q; // task-file result
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q; // bus flops
	logic [1:0] bresp_q, rresp_q; // bus responses
	logic [31:0] rdata_q; // read data flop

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// pins from outside the clock domain
	coc_sync #(.W(2)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({hpa_established_pin, security_enabled_pin}),
		.q(pin_s)
	);
	assign hpa_s = pin_s[1];
	assign sec_s = pin_s[0];

	// byte sum of the received overlay
	coc_csum u_csum (
		.clk_sys(clk_sys),
		.rst(rst),
		.clr(st_q == S_IDLE),
		.add(in_fire),
		.word(pio_in_data),
		.sum_q(rx_sum)
	);

	// other opcodes are not ours and pass untouched
	assign accept = tf_cmd_wr && (tf_command == OPC_OVERLAY) && (st_q == S_IDLE);
	assign ctrl_cancel = wr_do && (aw_addr_q == A_CTRL) && w_strb_q[0] && w_data_q[0];
	assign abort_xfer = ata_hard_reset || ata_soft_reset || ctrl_cancel;
	assign in_fire = pio_in_valid && pio_in_ready_q;
	assign out_fire = pio_out_valid_q && pio_out_ready;
	// a larger address than offered is left as it stands
	assign new_lba = (rx_lba_q > FULL_LBA) ? lba_q : rx_lba_q;

	// command decode, transfer sequencing and overlay checks
	always_comb begin
		st_d = st_q;
		fin = 1'b0;
		fin_abt = 1'b0;
		rsn = RSN_NONE;
		wloc = 8'h00;
		bloc = 8'h00;
		do_restore = 1'b0;
		do_freeze = 1'b0;
		do_apply = 1'b0;
		unique case (st_q)
			S_IDLE: begin
				if (accept && frozen_q) begin
					fin = 1'b1;
					fin_abt = 1'b1;
					rsn = RSN_FROZEN;
				end else if (accept) begin
					case (tf_feature)
						SUB_RESTORE: begin
							fin = 1'b1;
							if (hpa_s && (lba_q != FULL_LBA)) begin
								fin_abt = 1'b1;
								rsn = RSN_HPA;
								wloc = W_LBA0;
							end else begin
								do_restore = 1'b1;
							end
						end
						SUB_FREEZE: begin
							fin = 1'b1;
							do_freeze = 1'b1;
						end
						SUB_IDENTIFY: st_d = S_TX;
						SUB_SET: st_d = S_RX;
						default: begin
							fin = 1'b1;
							fin_abt = 1'b1;
						end
					endcase
				end
			end
			S_TX: begin
				if (out_fire && (wcnt_q == LAST_WORD)) begin
					st_d = S_IDLE;
					fin = 1'b1;
				end
			end
			S_RX: begin
				if (in_fire && (wcnt_q == LAST_WORD)) begin
					st_d = S_CHK;
				end
			end
			S_CHK: begin
				// checks run once the whole block is in
				st_d = S_IDLE;
				fin = 1'b1;
				if ((rx_sum != 8'h00) || (rx_sig_q != SIG_VAL)) begin
					fin_abt = 1'b1;
					rsn = RSN_CSUM;
					wloc = LAST_WORD;
				end else if (hpa_s && (new_lba != lba_q)) begin
					fin_abt = 1'b1;
					rsn = RSN_HPA;
					wloc = W_LBA0;
				end else if (sec_s && feat_q[SEC_BIT] && !rx_feat_q[SEC_BIT]) begin
					fin_abt = 1'b1;
					rsn = RSN_SECURITY;
					wloc = W_FEAT;
					bloc = SEC_BIT_LOC;
				end else begin
					do_apply = 1'b1;
				end
			end
			default: st_d = S_IDLE;
		endcase
		// a reset or cancel drops the transfer without completion
		if (abort_xfer) begin
			st_d = S_IDLE;
			fin = 1'b0;
			fin_abt = 1'b0;
			do_restore = 1'b0;
			do_freeze = 1'b0;
			do_apply = 1'b0;
		end
	end

	// state and word counter
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			wcnt_q <= 8'h00;
		end else begin
			st_q <= st_d;
			if (st_d == S_IDLE) begin
				wcnt_q <= 8'h00;
			end else if (in_fire || out_fire) begin
				wcnt_q <= wcnt_q + 8'h01;
			end
		end
	end

	// freeze lock: only the power-up reset clears it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frozen_q <= 1'b0;
		end else if (do_freeze) begin
			frozen_q <= 1'b1;
		end
	end

	// reported capabilities; overlay settings survive host resets
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mdma_q <= FULL_MDMA;
			udma_q <= FULL_UDMA;
			lba_q <= FULL_LBA;
			feat_q <= FULL_FEAT;
			feat2_q <= FULL_FEAT2;
		end else if (do_restore) begin
			mdma_q <= FULL_MDMA;
			udma_q <= FULL_UDMA;
			lba_q <= FULL_LBA;
			feat_q <= FULL_FEAT;
			feat2_q <= FULL_FEAT2;
		end else if (do_apply) begin
			mdma_q <= rx_mdma_q & FULL_MDMA;
			udma_q <= rx_udma_q & FULL_UDMA;
			lba_q <= new_lba;
			feat_q <= rx_feat_q & FULL_FEAT;
			feat2_q <= rx_feat2_q & FULL_FEAT2;
		end
	end

	// capture the overlay words that matter
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_mdma_q <= 16'h0000;
			rx_udma_q <= 16'h0000;
			rx_lba_q <= 48'h0;
			rx_feat_q <= 16'h0000;
			rx_feat2_q <= 16'h0000;
			rx_sig_q <= 8'h00;
		end else if (in_fire) begin
			unique case (wcnt_q)
				W_MDMA: rx_mdma_q <= pio_in_data;
				W_UDMA: rx_udma_q <= pio_in_data;
				W_LBA0: rx_lba_q[15:0] <= pio_in_data;
				W_LBA1: rx_lba_q[31:16] <= pio_in_data;
				W_LBA2: rx_lba_q[47:32] <= pio_in_data;
				W_FEAT: rx_feat_q <= pio_in_data;
				W_FEAT2: rx_feat2_q <= pio_in_data;
				LAST_WORD: rx_sig_q <= pio_in_data[7:0];
				default: rx_sig_q <= rx_sig_q; // other words only count to the sum
			endcase
		end
	end

	// identify block always shows the full set, never the reduced one
	always_comb begin
		unique case (st_q == S_TX ? wcnt_q + 8'h01 : W_REV)
			W_REV: out_d = REV_VAL;
			W_MDMA: out_d = FULL_MDMA;
			W_UDMA: out_d = FULL_UDMA;
			W_LBA0: out_d = FULL_LBA[15:0];
			W_LBA1: out_d = FULL_LBA[31:16];
			W_LBA2: out_d = FULL_LBA[47:32];
			W_FEAT: out_d = FULL_FEAT;
			W_FEAT2: out_d = FULL_FEAT2;
			LAST_WORD: out_d = {ID_CSUM, SIG_VAL};
			default: out_d = 16'h0000;
		endcase
	end

	// data-in and data-out handshake flops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pio_out_valid_q <= 1'b0;
			pio_out_data_q <= 16'h0000;
			pio_in_ready_q <= 1'b0;
		end else begin
			pio_in_ready_q <= (st_d == S_RX);
			if (st_d != S_TX) begin
				pio_out_valid_q <= 1'b0;
			end else if (st_q != S_TX || out_fire) begin
				pio_out_valid_q <= 1'b1;
				pio_out_data_q <= out_d;
			end
		end
	end

	// task-file result registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tf_done_q <= 1'b0;
			status_q <= 8'h40;
			error_q <= 8'h00;
			sc_q <= 8'h00;
			ch_q <= 8'h00;
			cl_q <= 8'h00;
		end else begin
			tf_done_q <= fin;
			if (fin) begin
				status_q <= 8'h00;
				status_q[ST_RDY] <= 1'b1;
				status_q[ST_ERR] <= fin_abt;
				error_q <= 8'h00;
				error_q[ER_ABT] <= fin_abt;
				sc_q <= rsn;
				ch_q <= wloc;
				cl_q <= bloc;
			end else if (st_d != st_q || abort_xfer) begin
				status_q <= 8'h00;
				status_q[ST_RDY] <= (st_d != S_CHK);
				status_q[ST_DRQ] <= (st_d == S_TX) || (st_d == S_RX);
				status_q[ST_BSY] <= (st_d == S_CHK);
				error_q <= 8'h00;
			end
		end
	end

	// bus write: address and data taken in either order
	assign wr_do = aw_held_q && w_held_q && !bvalid_q;
	assign wr_ok = (aw_addr_q == A_IRQ_STS) || (aw_addr_q == A_IRQ_MASK) || (aw_addr_q == A_CTRL);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid && wready_q) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				wready_q <= 1'b0;
			end
			if (wr_do) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// interrupt status: a new event wins over a write-one clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sts_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			sts_q <= (sts_q & ~((wr_do && aw_addr_q == A_IRQ_STS && w_strb_q[0])
				? w_data_q[IRQ_W-1:0] : '0)) | {fin_abt, fin};
			if (wr_do && aw_addr_q == A_IRQ_MASK && w_strb_q[0]) begin
				mask_q <= w_data_q[IRQ_W-1:0];
			end
			irq_q <= |(sts_q & mask_q);
		end
	end

	// bus read mux
	always_comb begin
		rd_d = 32'h0;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			A_IRQ_STS: rd_d[IRQ_W-1:0] = sts_q;
			A_IRQ_MASK: rd_d[IRQ_W-1:0] = mask_q;
			A_CTRL: rd_d = 32'h0;
			A_STATE: rd_d[7:0] = {1'b0, sec_s, hpa_s, frozen_q, st_q};
			A_ERR: rd_d[7:0] = error_q;
			A_STAT: rd_d[7:0] = status_q;
			A_REASON: rd_d[23:0] = {ch_q, cl_q, sc_q};
			A_CAP: rd_d = {feat2_q, feat_q};
			default: rd_ok = 1'b0;
		endcase
	end

	// bus read: one cycle from address to data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign pio_in_ready = pio_in_ready_q;
	assign pio_out_valid = pio_out_valid_q;
	assign pio_out_data = pio_out_data_q;
	assign tf_done = tf_done_q;
	assign tf_status = status_q;
	assign tf_error = error_q;
	assign tf_sector_count = sc_q;
	assign tf_cyl_high = ch_q;
	assign tf_cyl_low = cl_q;
	assign dco_frozen = frozen_q;
	assign cap_mdma = mdma_q;
	assign cap_udma = udma_q;
	assign cap_max_lba = lba_q;
	assign cap_feat = feat_q;
	assign cap_feat2 = feat2_q;
	assign irq = irq_q;

	// checks on the engine
	sequence rx_last_s;
		st_q == S_RX && in_fire && wcnt_q == LAST_WORD && !abort_xfer;
	endsequence
	sequence chk_done_s;
		st_q == S_CHK ##1 tf_done_q;
	endsequence
	AST_OPCODE_ONLY: assert property (
		tf_cmd_wr && tf_command != OPC_OVERLAY && st_q == S_IDLE |=> !tf_done_q)
		else $error("foreign opcode completed");
	AST_FROZEN_ABORT: assert property (
		accept && frozen_q && !abort_xfer |=> tf_done_q && error_q[ER_ABT])
		else $error("frozen command not aborted");
	AST_FROZEN_STICKY: assert property (frozen_q |=> frozen_q)
		else $error("freeze lock dropped");
	AST_RSV_ABORT: assert property (
		accept && !frozen_q && !abort_xfer && (tf_feature < SUB_RESTORE || tf_feature > SUB_SET)
		|=> error_q[ER_ABT] && status_q[ST_ERR]) else $error("reserved not aborted");
	AST_IDENT_START: assert property (
		accept && !frozen_q && !abort_xfer && tf_feature == SUB_IDENTIFY
		|=> pio_out_valid_q && pio_out_data_q == REV_VAL)
		else $error("identify block not started");
	AST_IDENT_FULL: assert property (
		st_q == S_TX && pio_out_valid_q && wcnt_q == W_FEAT |-> pio_out_data_q == FULL_FEAT)
		else $error("identify word not full");
	AST_RX_CHECK: assert property (rx_last_s |=> chk_done_s)
		else $error("set not checked after last word");
	AST_HPA_REPORT: assert property (
		st_q == S_CHK && !abort_xfer && rx_sum == 8'h00 && rx_sig_q == SIG_VAL && hpa_s
		&& new_lba != lba_q |=> sc_q == RSN_HPA && ch_q == W_LBA0 && error_q[ER_ABT])
		else $error("protected area abort misreported");
	AST_SUBSET: assert property (
		(feat_q & ~FULL_FEAT) == 16'h0000 && $stable(feat_q)
		|| do_restore || do_apply || $past(do_apply) || $past(do_restore))
		else $error("feature bits changed unasked");
endmodule : coc_overlay

//--- design/coc_overlay_dummy_unused.sv
// spare design unit, holds no logic
`timescale 1ns/10ps

//--- bench/coc_host_model.sv
// host controller model: pio data-in sink and data-out source
`timescale 1ns/10ps
module coc_host_model (
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic clr, // restart counts
	input wire logic stall, // host slow
	input wire logic [15:0] pio_out_data, // in word
	input wire logic pio_out_valid, // in valid
	output logic pio_out_ready, // host takes
	output logic [15:0] pio_in_data, // out word
	output logic pio_in_valid, // out valid
	input wire logic pio_in_ready // device takes
);
	logic [15:0] tx [256]; // block to send, loaded by the bench
	logic [15:0] rx [256]; // block received
	int rn; // words received
	int tn; // words sent
	// one word per valid and ready edge; a released word shows inverted
	always @(posedge clk_sys or posedge rst) begin
		if (rst || clr) begin
			rn <= 0;
			tn <= 0;
			pio_in_valid <= 1'b0;
			pio_in_data <= 16'h0000;
			pio_out_ready <= 1'b0;
		end else begin
			pio_out_ready <= !stall; // reads the whole block
			if (pio_out_valid && pio_out_ready) begin
				rx[rn[7:0]] <= pio_out_data;
				rn <= rn + 1;
			end
			if (pio_in_valid && pio_in_ready) begin
				tn <= tn + 1;
				pio_in_valid <= 1'b0;
				pio_in_data <= ~pio_in_data;
			end else if (!pio_in_valid && tn < 256 && !stall) begin
				pio_in_valid <= 1'b1;
				pio_in_data <= tx[tn[7:0]];
			end
		end
	end
endmodule : coc_host_model

//--- bench/coc_overlay_tb.sv
// self-checking bench of the overlay command handler
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module coc_overlay_tb
	import coc_pkg::*;
;
	logic clk_sys, rst, tf_cmd_wr, ata_hard_reset, ata_soft_reset, hpa_established_pin, clr;
	logic security_enabled_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, tf_command, tf_feature, tf_status, tf_error, s;
	logic [7:0] tf_sector_count, tf_cyl_high, tf_cyl_low;
	logic [31:0] s_axi_wdata, s_axi_rdata, r;
	logic [1:0] s_axi_bresp, s_axi_rresp, p;
	logic [15:0] pio_in_data, pio_out_data, cap_mdma, cap_udma, cap_feat, cap_feat2, u;
	logic pio_in_valid, pio_in_ready, pio_out_valid, pio_out_ready, tf_done, dco_frozen, irq;
	logic stall;
	logic [3:0] s_axi_wstrb;
	logic [47:0] cap_max_lba;
	logic [7:0] rsv [3] = '{8'h00, 8'hbf, 8'hc4}; // reserved subcodes
	logic [7:0] sub [4] = '{SUB_SET, SUB_FREEZE, SUB_IDENTIFY, SUB_RESTORE};
	int failures, checked, n, seed;
	coc_overlay dut_u (.*);
	coc_host_model host_u (.*);
	// free-running clock
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	// random host stalls pace both pio directions
	always @(posedge clk_sys) stall <= 1'($random(seed));
	task automatic conclude;
		if (failures == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic lim(input int m);
		if (n >= m) begin
			failures++;
			conclude();
		end
	endtask : lim
	// one register write, each channel released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 99 && !b; n++) begin
			@(negedge clk_sys);
			{aw, w, b, p} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk_sys);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
			if (b) s_axi_bready <= 0;
		end
		lim(99);
	endtask : axw
	task automatic axr(input logic [7:0] a);
		logic ar, v;
		v = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 99 && !v; n++) begin
			@(negedge clk_sys);
			{ar, v, r, p} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk_sys);
			if (ar) s_axi_arvalid <= 0;
			if (v) s_axi_rready <= 0;
		end
		lim(99);
	endtask : axr
	// issue one overlay subcommand and wait for its completion pulse
	task automatic cmd(input logic [7:0] f);
		@(posedge clk_sys);
		tf_cmd_wr <= 1;
		tf_feature <= f;
		clr <= 1;
		@(posedge clk_sys);
		tf_cmd_wr <= 0;
		clr <= 0;
		for (n = 0; n < 3000 && tf_done !== 1; n++) @(negedge clk_sys);
		lim(3000);
	endtask : cmd
	task automatic ab(input logic [7:0] c);
		`CHK("reason", c, tf_sector_count)
		`CHK("abort", 1'b1, tf_error[ER_ABT])
	endtask : ab
	task automatic pin(input logic [1:0] v);
		@(posedge clk_sys);
		{security_enabled_pin, hpa_established_pin} <= v;
		repeat (4) @(posedge clk_sys);
	endtask : pin
	// overlay block with its own checksum, bad skews it
	task automatic mk(input logic [15:0] ud, input logic [47:0] lb, input logic [7:0] bad);
		s = 8'ha5;
		for (int i = 0; i < 256; i++) host_u.tx[i] = 16'h0000;
		host_u.tx[0] = 16'h0002;
		host_u.tx[1] = FULL_MDMA;
		host_u.tx[2] = ud;
		{host_u.tx[5], host_u.tx[4], host_u.tx[3]} = lb;
		host_u.tx[7] = FULL_FEAT;
		host_u.tx[8] = FULL_FEAT2;
		for (int i = 0; i < 255; i++) s = s + host_u.tx[i][15:8] + host_u.tx[i][7:0];
		host_u.tx[255] = {8'h00 - s + bad, 8'ha5};
	endtask : mk
	task automatic idf;
		s = 0;
		for (int i = 0; i < 256; i++) s = s + host_u.rx[i][15:8] + host_u.rx[i][7:0];
		`CHK("count", 256, host_u.rn)
		`CHK("sum", 8'h00, s)
		`CHK("udma", FULL_UDMA, host_u.rx[2])
	endtask : idf
	initial begin
		seed = 32'h26ea75f2;
		{rst, clr, tf_cmd_wr, ata_hard_reset, ata_soft_reset, hpa_established_pin} = 6'h20;
		{security_enabled_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
		{s_axi_wdata, s_axi_wstrb, tf_feature, tf_command} = {32'h0, 4'hf, 8'h00, OPC_OVERLAY};
		failures = 0;
		checked = 0;
		repeat (12) @(posedge clk_sys);
		rst <= 0;
		axw(A_IRQ_MASK, 32'h2);
		cmd(SUB_IDENTIFY);
		idf();
		`CHK("irqmask", 1'b0, irq)
		u = $random(seed);
		u = (u & FULL_UDMA) | 16'h0080;
		mk(u, FULL_LBA - 1, 8'h00);
		cmd(SUB_SET);
		`CHK("set", {u & FULL_UDMA, FULL_LBA - 1, 8'h40}, {cap_udma, cap_max_lba, tf_status})
		cmd(SUB_IDENTIFY);
		idf();
		mk(u, FULL_LBA, 8'h01);
		cmd(SUB_SET);
		ab(RSN_CSUM);
		pin(1);
		cmd(SUB_RESTORE);
		ab(RSN_HPA);
		`CHK("word", 8'h03, tf_cyl_high)
		mk(u, FULL_LBA - 2, 8'h00);
		cmd(SUB_SET);
		ab(RSN_HPA);
		`CHK("setword", 8'h03, tf_cyl_high)
		pin(0);
		cmd(SUB_RESTORE);
		`CHK("full", {FULL_UDMA, FULL_LBA}, {cap_udma, cap_max_lba})
		`CHK("fullf", {FULL_MDMA, FULL_FEAT, FULL_FEAT2}, {cap_mdma, cap_feat, cap_feat2})
		// skew repays the cleared security bit
		mk(u, FULL_LBA, 8'h08);
		host_u.tx[W_FEAT][SEC_BIT] = 1'b0;
		pin(2);
		cmd(SUB_SET);
		ab(RSN_SECURITY);
		`CHK("loc", 16'h0703, {tf_cyl_high, tf_cyl_low})
		pin(0);
		foreach (rsv[i]) begin
			cmd(rsv[i]);
			ab(RSN_NONE);
			`CHK("err", 1'b1, tf_status[ST_ERR])
		end
		repeat (2) @(negedge clk_sys);
		`CHK("irq", 1'b1, irq)
		axw(A_IRQ_STS, 32'h3);
		`CHK("bresp", RESP_OKAY, p)
		repeat (2) @(negedge clk_sys);
		`CHK("irqclr", 1'b0, irq)
		axr(8'h20);
		`CHK("slverr", {RESP_SLVERR, 32'h0}, {p, r})
		// a cancel write drops an identify transfer without completion
		@(posedge clk_sys);
		{tf_cmd_wr, tf_feature} <= {1'b1, SUB_IDENTIFY};
		@(posedge clk_sys);
		tf_cmd_wr <= 1'b0;
		axw(A_CTRL, 32'h1);
		@(negedge clk_sys);
		`CHK("cancel", {2'b00, 8'h40}, {pio_out_valid, tf_done, tf_status})
		cmd(SUB_FREEZE);
		@(posedge clk_sys);
		{ata_hard_reset, ata_soft_reset} <= 2'b11;
		@(posedge clk_sys);
		{ata_hard_reset, ata_soft_reset} <= 2'b00;
		foreach (sub[i]) begin
			cmd(sub[i]);
			ab(RSN_FROZEN);
		end
		`CHK("frozen", 1'b1, dco_frozen)
		conclude();
	end
endmodule : coc_overlay_tb
